// *** core/reader_irq_enable.sv ***
// interrupt enable, pin routing and fault flags of a contactless reader
// assumes all event inputs come from logic on clk as one-cycle pulses
//
// Our own choice: register access over AXI4-Lite.
module reader_irq_enable (
  input wire logic clk,
  input wire logic rst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [reader_irq_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [reader_irq_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic highAlert,
  input wire logic lowAlert,
  input wire logic cmdDone,
  input wire logic txDone,
  input wire logic sofSeen,
  input wire logic cardPresence,
  input wire logic [4:0] timerUnderflow,
  input wire logic nvCmdDone,
  input wire logic nvCmdFailed,
  input wire logic fifoWrite,
  input wire logic fifoFull,
  input wire logic fifoEmpty,
  input wire logic cmdStart,
  input wire logic rxCmdStart,
  input wire logic waitDataEntry,
  input wire logic errorsStored,
  input wire logic crcSending,
  input wire logic authActive,
  input wire logic sendRequest,
  input wire logic frameEnd,
  input wire logic sofValid,
  input wire logic [7:0] frameBits,
  input wire logic collision,
  input wire logic collisionInEof,
  input wire logic [6:0] collisionPos,
  input wire logic stopBitBad,
  input wire logic sofEofBad,
  input wire logic byteCountBad,
  input wire logic parityBad,
  input wire logic crcBad,
  input wire logic [2:0] linkState,
  input wire logic cipherOn,
  output logic irqPinOut,
  output logic irqPinOe,
  output logic fifoWriteAccept,
  output logic frameDiscard,
  output logic rxHalt,
  output logic lastByteDrop,
  output logic [6:0] firstCollPos,
  output logic firstCollValid
);
  import reader_irq_pkg::*;

  typedef struct packed {
    logic awRdy;
    logic awHeld;
    logic [5:0] awIdx;
    logic wRdy;
    logic wHeld;
    logic [7:0] wByte;
    logic wLane;
    logic bValid;
    logic [1:0] bResp;
    logic arRdy;
    logic rValid;
    logic [7:0] rByte;
    logic [1:0] rResp;
    logic [7:0] enA;
    logic [7:0] enB;
    logic [6:0] reqA;
    logic [5:0] reqB;
    logic combined;
    logic [7:0] faults;
    logic cipher;
    logic [2:0] link;
    logic [2:0] opt;
    logic [6:0] collPos;
    logic collValid;
    logic pinOut;
    logic pinOe;
    logic wrAccept;
    logic discard;
    logic halt;
    logic dropByte;
  } state_t;

  state_t st_q;
  state_t st_d;
  logic wrGo;
  logic shortFrame;
  logic protSet;
  logic collSet;
  logic integSet;
  logic wconfSet;
  logic ovfSet;
  logic emptySet;
  logic rxClear;

  function automatic logic mapped(input logic [5:0] idx);
    mapped = (idx == IDX_REQUEST_A) || (idx == IDX_REQUEST_B) || (idx == IDX_ENABLE_A) ||
             (idx == IDX_ENABLE_B) || (idx == IDX_FAULT) || (idx == IDX_STATUS) ||
             (idx == IDX_OPTIONS);
  endfunction

  function automatic logic rxPhase(input logic [2:0] ls);
    rxPhase = (ls == LS_RX_WAIT) || (ls == LS_WAIT_DATA) || (ls == LS_RECEIVING);
  endfunction

  // write performs once both address and data are held, before any answer is pending
  assign wrGo = st_q.awHeld && st_q.wHeld && !st_q.bValid;

  assign shortFrame = frameEnd && sofValid && ((frameBits < MIN_FRAME_BITS) ||
                      (st_q.opt[OPT_EMD] && (frameBits < MIN_EMD_BITS)));
  assign protSet = stopBitBad || sofEofBad || byteCountBad;
  assign collSet = collision && !collisionInEof;
  assign integSet = parityBad || crcBad || (collSet && st_q.opt[OPT_COLLISION_AS_INTEGRITY]);
  assign wconfSet = fifoWrite && (crcSending || authActive || rxPhase(linkState));
  assign ovfSet = fifoWrite && fifoFull;
  assign emptySet = sendRequest && fifoEmpty;
  assign rxClear = rxCmdStart || waitDataEntry;

  always_comb begin
    st_d = st_q;
    st_d.discard = 1'b0;
    st_d.halt = 1'b0;
    st_d.dropByte = 1'b0;
    // bus channels
    if (awvalid && st_q.awRdy) begin
      st_d.awHeld = 1'b1;
      st_d.awIdx = awaddr[7:2];
    end
    if (wvalid && st_q.wRdy) begin
      st_d.wHeld = 1'b1;
      st_d.wByte = wdata[7:0];
      st_d.wLane = wstrb[0];
    end
    if (st_q.bValid && bready) begin
      st_d.bValid = 1'b0;
    end
    if (wrGo) begin
      st_d.awHeld = 1'b0;
      st_d.wHeld = 1'b0;
      st_d.bValid = 1'b1;
      st_d.bResp = mapped(st_q.awIdx) ? RESP_OKAY : RESP_SLVERR;
      // narrow registers live in lane 0; other lanes are dropped
      if (st_q.wLane) begin
        case (st_q.awIdx)
          IDX_REQUEST_A: begin
            // set or clear by bit 7
            if (st_q.wByte[BIT_SETCLR]) begin
              st_d.reqA = st_q.reqA | st_q.wByte[6:0];
            end else begin
              st_d.reqA = st_q.reqA & ~st_q.wByte[6:0];
            end
          end
          IDX_REQUEST_B: begin
            // set or clear by bit 7
            if (st_q.wByte[BIT_SETCLR]) begin
              st_d.reqB = st_q.reqB | st_q.wByte[5:0];
            end else begin
              st_d.reqB = st_q.reqB & ~st_q.wByte[5:0];
            end
          end
          IDX_ENABLE_A: st_d.enA = st_q.wByte;
          IDX_ENABLE_B: st_d.enB = st_q.wByte;
          IDX_STATUS: begin
            // cipher can only be switched off from software
            if (!st_q.wByte[BIT_CIPHER]) begin
              st_d.cipher = 1'b0;
            end
          end
          IDX_OPTIONS: st_d.opt = st_q.wByte[2:0];
          default: st_d.opt = st_d.opt;
        endcase
      end
    end
    st_d.awRdy = !st_d.awHeld && !st_d.bValid;
    st_d.wRdy = !st_d.wHeld && !st_d.bValid;
    // read channel: one outstanding read, data captured at address acceptance
    if (st_q.rValid && rready) begin
      st_d.rValid = 1'b0;
    end
    if (arvalid && st_q.arRdy) begin
      st_d.rValid = 1'b1;
      st_d.rResp = mapped(araddr[7:2]) ? RESP_OKAY : RESP_SLVERR;
      case (araddr[7:2])
        IDX_REQUEST_A: st_d.rByte = {1'b0, st_q.reqA};
        IDX_REQUEST_B: st_d.rByte = {1'b0, st_q.combined, st_q.reqB};
        IDX_ENABLE_A: st_d.rByte = st_q.enA;
        IDX_ENABLE_B: st_d.rByte = st_q.enB;
        IDX_FAULT: st_d.rByte = st_q.faults;
        IDX_STATUS: st_d.rByte = {2'h0, st_q.cipher, 2'h0, st_q.link};
        IDX_OPTIONS: st_d.rByte = {5'h00, st_q.opt};
        default: st_d.rByte = 8'h00;
      endcase
    end
    st_d.arRdy = !st_d.rValid;
    st_d.link = linkState;
    if (cipherOn) begin
      st_d.cipher = 1'b1;
    end
    // fault clears come first so a coinciding set wins
    if (cmdStart) begin
      st_d.faults[F_OVF] = 1'b0;
      st_d.faults[F_EMPTY] = 1'b0;
    end
    if ((cmdStart && !st_q.opt[OPT_MULTI]) || (errorsStored && st_q.opt[OPT_MULTI])) begin
      st_d.faults[F_WCONF] = 1'b0;
    end
    if (rxClear) begin
      st_d.faults[F_SHORT] = 1'b0;
      st_d.faults[F_COLL] = 1'b0;
      st_d.faults[F_PROT] = 1'b0;
      st_d.faults[F_INTEG] = 1'b0;
      st_d.collValid = 1'b0;
    end
    if (nvCmdDone) begin
      st_d.faults[F_NV] = nvCmdFailed;
    end
    if (wconfSet) begin
      st_d.faults[F_WCONF] = 1'b1;
    end
    if (ovfSet) begin
      st_d.faults[F_OVF] = 1'b1;
    end
    if (shortFrame) begin
      st_d.faults[F_SHORT] = 1'b1;
      st_d.discard = 1'b1;
    end
    if (emptySet) begin
      st_d.faults[F_EMPTY] = 1'b1;
    end
    if (collSet) begin
      st_d.faults[F_COLL] = 1'b1;
      if (!st_d.collValid) begin
        st_d.collPos = collisionPos;
        st_d.collValid = 1'b1;
      end
    end
    if (protSet) begin
      st_d.faults[F_PROT] = 1'b1;
      st_d.halt = 1'b1;
      st_d.dropByte = 1'b1;
    end
    if (integSet) begin
      st_d.faults[F_INTEG] = 1'b1;
    end
    st_d.wrAccept = fifoWrite && !fifoFull && !st_q.faults[F_OVF];
    // request events win over a software clear
    st_d.reqA[RQ_HIGH] = st_d.reqA[RQ_HIGH] | highAlert;
    st_d.reqA[RQ_LOW] = st_d.reqA[RQ_LOW] | lowAlert;
    st_d.reqA[RQ_DONE] = st_d.reqA[RQ_DONE] | cmdDone;
    st_d.reqA[RQ_TX] = st_d.reqA[RQ_TX] | txDone;
    // no receive request for a discarded frame
    st_d.reqA[RQ_RX] = st_d.reqA[RQ_RX] | (frameEnd && !shortFrame);
    st_d.reqA[RQ_ERR] = st_d.reqA[RQ_ERR] | wconfSet | ovfSet | protSet | emptySet | integSet;
    st_d.reqA[RQ_SOF] = st_d.reqA[RQ_SOF] | sofSeen;
    st_d.reqB[RQ_CARD] = st_d.reqB[RQ_CARD] | cardPresence;
    st_d.reqB[4:0] = st_d.reqB[4:0] | timerUnderflow;
    st_d.combined = (|(st_d.reqA & st_d.enA[6:0])) || (|(st_d.reqB & st_d.enB[5:0]));
    // pin lags combined by a cycle so it comes straight from a flop
    // route gate
    if (st_q.enB[BIT_TOTEM]) begin
      st_d.pinOut = (st_q.combined && st_q.enB[BIT_ROUTE]) ^ st_q.enA[BIT_INVERT];
      st_d.pinOe = 1'b1;
    end else begin
      st_d.pinOut = 1'b0;
      st_d.pinOe = !((st_q.combined && st_q.enB[BIT_ROUTE]) ^ st_q.enA[BIT_INVERT]);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      st_q.awRdy <= 1'b1;
      st_q.wRdy <= 1'b1;
      st_q.arRdy <= 1'b1;
      st_q.enA <= RST_ENABLE;
      st_q.enB <= RST_ENABLE;
      st_q.reqA <= RST_REQ_A;
      st_q.reqB <= RST_REQ_B;
      st_q.faults <= RST_FAULT;
      st_q.opt <= RST_OPTIONS;
      st_q.pinOe <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign awready = st_q.awRdy;
  assign wready = st_q.wRdy;
  assign bvalid = st_q.bValid;
  assign bresp = st_q.bResp;
  assign arready = st_q.arRdy;
  assign rvalid = st_q.rValid;
  assign rdata = {24'h000000, st_q.rByte};
  assign rresp = st_q.rResp;
  assign irqPinOut = st_q.pinOut;
  assign irqPinOe = st_q.pinOe;
  assign fifoWriteAccept = st_q.wrAccept;
  assign frameDiscard = st_q.discard;
  assign rxHalt = st_q.halt;
  assign lastByteDrop = st_q.dropByte;
  assign firstCollPos = st_q.collPos;
  assign firstCollValid = st_q.collValid;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  pin_invert_a: assert property (
    (st_q.enB[BIT_TOTEM] && st_q.enB[BIT_ROUTE] && st_q.combined) |=>
    (irqPinOe && (irqPinOut == !$past(st_q.enA[BIT_INVERT]))))
    else $error("pin level not inverted as configured");
  gate_a_sof_a: assert property (
    (sofSeen && st_q.enA[RQ_SOF] && !wrGo) |=> (st_q.reqA[RQ_SOF] && st_q.combined))
    else $error("enabled frame start did not reach combined request");
  gate_b_timer_a: assert property (
    (timerUnderflow[0] && st_q.enB[0] && !wrGo) |=> st_q.combined)
    else $error("enabled timer underflow did not reach combined request");
  route_off_a: assert property (
    !st_q.enB[BIT_ROUTE] |=>
    (irqPinOut == ($past(st_q.enB[BIT_TOTEM]) && $past(st_q.enA[BIT_INVERT]))))
    else $error("unrouted pin not at inactive level");
  open_drain_a: assert property (
    !st_q.enB[BIT_TOTEM] |=> !irqPinOut)
    else $error("open-drain pin drove high");
  nv_fault_a: assert property (
    (nvCmdDone && nvCmdFailed) |=> st_q.faults[F_NV])
    else $error("nonvolatile fault not flagged");
  write_conflict_a: assert property (
    (fifoWrite && authActive) |=> (st_q.faults[F_WCONF] && st_q.reqA[RQ_ERR]))
    else $error("conflicting buffer write not flagged");
  conflict_clear_a: assert property (
    (cmdStart && !st_q.opt[OPT_MULTI] && !wconfSet) |=> !st_q.faults[F_WCONF])
    else $error("write conflict not cleared at command start");
  overflow_block_a: assert property (
    st_q.faults[F_OVF] |=> !fifoWriteAccept)
    else $error("buffer write accepted while overflow set");
  short_frame_a: assert property (
    (frameEnd && sofValid && (frameBits < MIN_FRAME_BITS)) |=>
    (frameDiscard && st_q.faults[F_SHORT] && !$rose(st_q.reqA[RQ_RX])))
    else $error("short frame not discarded");
  emd_short_a: assert property (
    (frameEnd && sofValid && st_q.opt[OPT_EMD] && (frameBits < MIN_EMD_BITS)) |=> frameDiscard)
    else $error("frame under three bytes not discarded");
  rx_clear_a: assert property (
    (rxClear && !protSet) |=> !st_q.faults[F_PROT])
    else $error("protocol fault survived receive start");
  empty_send_a: assert property (
    (sendRequest && fifoEmpty) |=> st_q.faults[F_EMPTY])
    else $error("empty send not flagged");
  collision_a: assert property (
    (collision && !collisionInEof) |=> (st_q.faults[F_COLL] && firstCollValid))
    else $error("collision not flagged");
  protocol_halt_a: assert property (
    protSet |=> (rxHalt && lastByteDrop && st_q.faults[F_PROT]))
    else $error("protocol fault did not halt reception");
  coll_integ_a: assert property (
    (collision && !collisionInEof && st_q.opt[OPT_COLLISION_AS_INTEGRITY]) |=> st_q.faults[F_INTEG])
    else $error("collision did not set integrity fault");
  combined_a: assert property (
    (highAlert && st_q.enA[RQ_HIGH] && !wrGo) |=> (st_q.combined && st_q.reqA[RQ_HIGH]))
    else $error("enabled high alert did not raise combined request");
endmodule // reader_irq_enable

// *** core/reader_irq_pkg.sv ***
// constants for the interrupt enable, routing and fault flag block
// assumes a 32-bit axi4-lite master; register index times four is the byte address
package reader_irq_pkg;
  localparam int ADDR_W = 8;
  // register indices
  localparam logic [5:0] IDX_REQUEST_A = 6'h06;
  localparam logic [5:0] IDX_REQUEST_B = 6'h07;
  localparam logic [5:0] IDX_ENABLE_A = 6'h08;
  localparam logic [5:0] IDX_ENABLE_B = 6'h09;
  localparam logic [5:0] IDX_FAULT = 6'h0a;
  localparam logic [5:0] IDX_STATUS = 6'h0b;
  localparam logic [5:0] IDX_OPTIONS = 6'h20;
  // reset values
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_FAULT = 8'h00;
  localparam logic [6:0] RST_REQ_A = 7'h00;
  localparam logic [5:0] RST_REQ_B = 6'h00;
  localparam logic [2:0] RST_OPTIONS = 3'h0;
  // field positions
  localparam int BIT_SETCLR = 7;
  localparam int BIT_INVERT = 7;
  localparam int BIT_ROUTE = 6;
  localparam int BIT_TOTEM = 7;
  localparam int BIT_COMBINED = 6;
  localparam int BIT_CIPHER = 5;
  localparam int RQ_HIGH = 6;
  localparam int RQ_LOW = 5;
  localparam int RQ_DONE = 4;
  localparam int RQ_TX = 3;
  localparam int RQ_RX = 2;
  localparam int RQ_ERR = 1;
  localparam int RQ_SOF = 0;
  localparam int RQ_CARD = 5;
  localparam int F_NV = 7;
  localparam int F_WCONF = 6;
  localparam int F_OVF = 5;
  localparam int F_SHORT = 4;
  localparam int F_EMPTY = 3;
  localparam int F_COLL = 2;
  localparam int F_PROT = 1;
  localparam int F_INTEG = 0;
  localparam int OPT_COLLISION_AS_INTEGRITY = 0;
  localparam int OPT_MULTI = 1;
  localparam int OPT_EMD = 2;
  // frame length limits in bits
  localparam logic [7:0] MIN_FRAME_BITS = 8'h04;
  localparam logic [7:0] MIN_EMD_BITS = 8'h18;
  // link state codes
  localparam logic [2:0] LS_IDLE = 3'h0;
  localparam logic [2:0] LS_TX_WAIT = 3'h1;
  localparam logic [2:0] LS_SENDING = 3'h3;
  localparam logic [2:0] LS_RX_WAIT = 3'h5;
  localparam logic [2:0] LS_WAIT_DATA = 3'h6;
  localparam logic [2:0] LS_RECEIVING = 3'h7;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** test/host_model.sv ***
// host side of the register bus: axi4-lite master tasks and the pin pull-up
// assumes the block answers on clk; only the bench timeout ends a wait
module host_model (
  input wire logic clk,
  output logic awvalid = 1'b0,
  output logic [7:0] awaddr = 8'h00,
  output logic [2:0] awprot = 3'h0,
  output logic wvalid = 1'b0,
  output logic [31:0] wdata = 32'h0,
  output logic [3:0] wstrb = 4'hf,
  output logic bready = 1'b0,
  output logic arvalid = 1'b0,
  output logic [7:0] araddr = 8'h00,
  output logic [2:0] arprot = 3'h0,
  output logic rready = 1'b0,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic [1:0] bresp,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic irqPinOut,
  input wire logic irqPinOe,
  output wire logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // open drain needs a pull-up: a released pin reads high
  assign pin = irqPinOe ? irqPinOut : 1'b1;

  // ready and the answer are read at the rising edge that takes them; each channel lets go there
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic [1:0] tk;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tk = 2'b00;
    do begin
      @(posedge clk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
        tk[1] = 1'b1;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~{24'h0, d};
        tk[0] = 1'b1;
      end
    end while (tk != 2'b11);
    while (!bvalid) @(posedge clk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic tk;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tk = 1'b0;
    do begin
      @(posedge clk);
      tk = arready;
    end while (!tk);
    arvalid <= 1'b0;
    araddr <= ~a;
    while (!rvalid) @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule // host_model

// *** test/test_reader_irq_enable.sv ***
// regression bench for the interrupt enable, routing and fault flag block
// assumes host_model speaks the register bus and resolves the interrupt pin
module test_reader_irq_enable;
  timeunit 1ns;
  timeprecision 1ps;
  import reader_irq_pkg::*;
  localparam logic [7:0] A_RA = {IDX_REQUEST_A, 2'b00}, A_RB = {IDX_REQUEST_B, 2'b00};
  localparam logic [7:0] A_EA = {IDX_ENABLE_A, 2'b00}, A_EB = {IDX_ENABLE_B, 2'b00};
  localparam logic [7:0] A_F = {IDX_FAULT, 2'b00}, A_ST = {IDX_STATUS, 2'b00};
  localparam logic [7:0] A_OP = {IDX_OPTIONS, 2'b00};
  localparam logic [25:0] NV = 26'h800, FW = 26'h1000, CS = 26'h2000, RS = 26'h4000;
  localparam logic [25:0] WD = 26'h8000, ES = 26'h10000, SR = 26'h20000, FE = 26'h40000;
  localparam logic [25:0] CO = 26'h80000, CI = 26'h2000000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [25:0] ev = '0;
  logic nvFail = 1'b0, full = 1'b0, empty = 1'b0, crc = 1'b0, auth = 1'b0;
  logic sofV = 1'b0, inEof = 1'b0;
  logic [7:0] fBits = 8'h00;
  logic [6:0] cPos = 7'h00;
  logic [2:0] lState = 3'h0;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, po;
  logic [1:0] bresp, rresp, r;
  logic irqPinOut, irqPinOe, pin, fwa, fdis, halt, drop, cValid;
  logic [6:0] cFirst;
  logic [7:0] ea, eb, ra, rb, ef, m;
  logic [15:0] corner [3] = '{16'h00c0, 16'h8040, 16'hff3f};
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
  int failures = 0, cmp_count = 0, cyc = 0;

  reader_irq_enable uut (
    .clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .highAlert(ev[0]), .lowAlert(ev[1]), .cmdDone(ev[2]), .txDone(ev[3]),
    .sofSeen(ev[4]), .cardPresence(ev[5]), .timerUnderflow(ev[10:6]), .nvCmdDone(ev[11]),
    .nvCmdFailed(nvFail), .fifoWrite(ev[12]), .fifoFull(full), .fifoEmpty(empty),
    .cmdStart(ev[13]), .rxCmdStart(ev[14]), .waitDataEntry(ev[15]), .errorsStored(ev[16]),
    .crcSending(crc), .authActive(auth), .sendRequest(ev[17]), .frameEnd(ev[18]),
    .sofValid(sofV), .frameBits(fBits), .collision(ev[19]), .collisionInEof(inEof),
    .collisionPos(cPos), .stopBitBad(ev[20]), .sofEofBad(ev[21]), .byteCountBad(ev[22]),
    .parityBad(ev[23]), .crcBad(ev[24]), .linkState(lState), .cipherOn(ev[25]),
    .irqPinOut(irqPinOut), .irqPinOe(irqPinOe), .fifoWriteAccept(fwa), .frameDiscard(fdis),
    .rxHalt(halt), .lastByteDrop(drop), .firstCollPos(cFirst), .firstCollValid(cValid)
  );
  host_model host (
    .clk(clk), .awvalid(awvalid), .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid),
    .wdata(wdata), .wstrb(wstrb), .bready(bready), .arvalid(arvalid), .araddr(araddr),
    .arprot(arprot), .rready(rready), .awready(awready), .wready(wready), .bvalid(bvalid),
    .bresp(bresp), .arready(arready), .rvalid(rvalid), .rdata(rdata), .rresp(rresp),
    .irqPinOut(irqPinOut), .irqPinOe(irqPinOe), .pin(pin)
  );

  initial forever #4 clk = ~clk;

  function automatic logic cmb(logic [7:0] a, logic [7:0] b, logic [7:0] x, logic [7:0] y);
    return (|(a[6:0] & x[6:0])) | (|(b[5:0] & y[5:0]));
  endfunction
  // returns {enable, wire level}; open drain releases when the level is high
  function automatic logic [1:0] pinx(logic c, logic [7:0] x, logic [7:0] y);
    logic l;
    l = (c & y[6]) ^ x[7];
    return {y[7] | !l, l};
  endfunction

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic ck(input logic [39:0] g, input logic [39:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rk(input logic [7:0] a, input logic [31:0] e);
    host.rd(a, d, r);
    ck({r, d}, {RESP_OKAY, e});
  endtask
  task automatic wk(input logic [7:0] a, input logic [7:0] v);
    host.wr(a, v, r);
    ck(r, RESP_OKAY);
  endtask
  task automatic cf();
    rk(A_F, {24'h0, ef});
  endtask
  // pulse outputs stand one cycle, so they are caught at the falling edge after the take
  task automatic pulse(input logic [25:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= '0;
    @(negedge clk);
    po = {fwa, fdis, halt, drop};
    @(posedge clk);
  endtask

  // under a thousand cycles suffice; the ceiling leaves wide margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      end_sim();
    end
  end

  initial begin
    void'($urandom(74));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rk(A_EA, 0);
    rk(A_EB, 0);
    rk(A_F, 0);
    rk(A_RB, 0);
    ck({irqPinOe, pin}, pinx(1'b0, 8'h00, 8'h00));
    host.rd(8'h40, d, r);
    ck({r, d}, {RESP_SLVERR, 32'h0});
    host.wr(8'h40, 8'hff, r);
    ck(r, RESP_SLVERR);
    host.wstrb <= 4'h0;
    wk(A_EA, 8'hff);
    host.wstrb <= 4'hf;
    rk(A_EA, 0);
    $display("test reset_and_bus done");
    for (int i = 0; i < 12; i++) begin
      {ea, eb} = (i < 3) ? corner[i] : 16'($urandom);
      wk(A_EA, ea);
      wk(A_EB, eb);
      ra = (i < 3) ? 8'h7f : 8'($urandom) & 8'h7f;
      rb = (i < 3) ? 8'h3f : 8'($urandom) & 8'h3f;
      wk(A_RA, 8'h7f);
      wk(A_RB, 8'h3f);
      wk(A_RA, ra | 8'h80);
      wk(A_RB, rb | 8'h80);
      m = 8'($urandom) & 8'h7f;
      wk(A_RA, m);
      ra = ra & ~m;
      rk(A_RA, ra);
      rk(A_RB, {cmb(ra, rb, ea, eb), rb[5:0]});
      ck({irqPinOe, pin}, pinx(cmb(ra, rb, ea, eb), ea, eb));
    end
    wk(A_EA, 8'h7f);
    wk(A_EB, 8'h3f);
    wk(A_RA, 8'h7f);
    wk(A_RB, 8'h3f);
    pulse(26'h7ff);
    rk(A_RA, 8'h79);
    rk(A_RB, 8'h7f);
    $display("test routing done");
    ef = 8'h00;
    pulse(CS | RS);
    cf();
    nvFail <= 1'b1;
    pulse(NV);
    ef = 8'h80;
    cf();
    crc <= 1'b1;
    pulse(FW);
    ck(po[3], 1'b1);
    crc <= 1'b0;
    ef = 8'hc0;
    cf();
    host.rd(A_RA, d, r);
    ck(d[RQ_ERR], 1'b1);
    pulse(CS);
    ef = 8'h80;
    cf();
    full <= 1'b1;
    pulse(FW);
    ck(po[3], 1'b0);
    full <= 1'b0;
    pulse(FW);
    ck(po[3], 1'b0);
    ef = 8'ha0;
    cf();
    empty <= 1'b1;
    pulse(SR);
    empty <= 1'b0;
    ef = 8'ha8;
    cf();
    sofV <= 1'b1;
    fBits <= 8'h04;
    pulse(FE);
    ck(po[2], 1'b0);
    fBits <= 8'h03;
    pulse(FE);
    ck(po[2], 1'b1);
    ef = 8'hb8;
    cf();
    inEof <= 1'b1;
    pulse(CO);
    cf();
    inEof <= 1'b0;
    cPos <= 7'($urandom);
    pulse(CO);
    ef = 8'hbc;
    cf();
    ck({cValid, cFirst}, {1'b1, cPos});
    for (int k = 0; k < 3; k++) begin
      pulse(RS);
      pulse(26'h100000 << k);
      ck(po[1:0], 2'b11);
      ef = (ef & 8'he8) | 8'h02;
      cf();
    end
    for (int k = 0; k < 2; k++) begin
      pulse(26'h800000 << k);
      ef = ef | 8'h01;
      cf();
      pulse(WD);
      ef = ef & 8'he8;
      cf();
    end
    wk(A_OP, 8'h04);
    fBits <= 8'h18;
    pulse(FE);
    ck(po[2], 1'b0);
    fBits <= 8'h17;
    pulse(FE);
    ck(po[2], 1'b1);
    ef = ef | 8'h10;
    cf();
    wk(A_OP, 8'h01);
    pulse(RS);
    pulse(CO);
    ef = (ef & 8'he8) | 8'h05;
    cf();
    wk(A_OP, 8'h02);
    pulse(CS);
    auth <= 1'b1;
    pulse(FW);
    auth <= 1'b0;
    pulse(CS);
    ef = (ef & 8'h97) | 8'h40;
    cf();
    pulse(ES);
    ef = ef & 8'hbf;
    cf();
    wk(A_OP, 8'h00);
    $display("test fault_flags done");
    foreach (codes[k]) begin
      lState <= codes[k];
      rk(A_ST, {29'h0, codes[k]});
    end
    pulse(CI);
    rk(A_ST, 32'h27);
    wk(A_ST, 8'h00);
    rk(A_ST, 32'h07);
    pulse(FW);
    ef = ef | 8'h40;
    cf();
    $display("test link_status done");
    end_sim();
  end
endmodule // test_reader_irq_enable
